//--- rtl/acpc_conv_ctrl.sv
// What this block does
// - Both reference power-down inputs low: bandgap, buffer, temp sensor on.
// - Core power-down high, buffer low: internal reference off, buffer on.
// - Both reference power-down inputs high: reference and buffer off.
// - Power-down pin high puts the converter in minimum-current state.
// - Power-down waits for running conversion; register bus stays active.
// - Register power-down control makes the power-down pin ignored.
// - Falling edge of convert_start_n alone starts a conversion.
// - A started conversion always completes; nothing restarts or aborts it.
// - Convert start works regardless of chip-select and read-enable.
// - Impulse mode: low-current state after each conversion until next.
// - Impulse mode keeps the digital interface operational.
// - Busy falls at conversion end; result then readable.
`timescale 1ns/1ps
`include "acpc_defs.svh"
module acpc_conv_ctrl #(
  parameter int CONV_CYCLES = `ACPC_CONV_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic convert_start_n,
  input wire logic powerdown_pin,
  input wire logic ref_core_powerdown,
  input wire logic ref_buffer_powerdown,
  input wire logic chip_select_n,
  input wire logic read_enable_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic busy,
  output logic conv_done,
  output logic powered_down,
  output logic low_power,
  output acpc_pkg::acpc_ref_mode_t ref_mode,
  output acpc_pkg::acpc_ref_ctrl_t ref_ctrl
);

  typedef enum logic [1:0] {
    ACPC_ST_IDLE,
    ACPC_ST_CONVERT,
    ACPC_ST_POWERDOWN
  } acpc_state_t;

  localparam int CW = $clog2(CONV_CYCLES + 1);

  acpc_state_t state;
  acpc_pkg::acpc_cfg_t cfg;
  logic cnv_prev;
  logic start_edge;
  logic pd_request;
  logic [CW-1:0] cycle_cnt;
  logic [CW-1:0] busy_run;
  logic [15:0] conv_count;
  logic [31:0] status_word;

  // Chip select and read enable play no part in starting
  assign start_edge = cnv_prev && !convert_start_n;
  // Register control owns power-down when enabled
  assign pd_request = cfg.sw_pd_en ? cfg.sw_pd : powerdown_pin;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnv_prev <= 1'b1;
    end else begin
      cnv_prev <= convert_start_n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= ACPC_ST_IDLE;
      cycle_cnt <= '0;
    end else begin
      unique case (state)
        ACPC_ST_IDLE: begin
          if (start_edge) begin
            state <= ACPC_ST_CONVERT;
            cycle_cnt <= CW'(CONV_CYCLES - 1);
          end else if (pd_request) begin
            state <= ACPC_ST_POWERDOWN;
          end
        end
        ACPC_ST_CONVERT: begin
          // Start edges are ignored here; power-down is only looked at in the last cycle
          if (cycle_cnt == '0) begin
            state <= pd_request ? ACPC_ST_POWERDOWN : ACPC_ST_IDLE;
          end else begin
            cycle_cnt <= cycle_cnt - 1'b1;
          end
        end
        ACPC_ST_POWERDOWN: begin
          if (!pd_request) begin
            state <= ACPC_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      conv_done <= 1'b0;
      conv_count <= 16'h0000;
    end else begin
      conv_done <= (state == ACPC_ST_CONVERT) && (cycle_cnt == '0);
      if ((state == ACPC_ST_CONVERT) && (cycle_cnt == '0)) begin
        conv_count <= conv_count + 16'h0001;
      end
    end
  end

  assign busy = (state == ACPC_ST_CONVERT);
  assign powered_down = (state == ACPC_ST_POWERDOWN);
  // Impulse mode idles analog between conversions; only analog affected
  assign low_power = powered_down ||
                     (cfg.impulse && state == ACPC_ST_IDLE);

  acpc_ref_decode u_ref (
    .ref_core_powerdown(ref_core_powerdown),
    .ref_buffer_powerdown(ref_buffer_powerdown),
    .powered_down(powered_down),
    .ref_mode(ref_mode),
    .ref_ctrl(ref_ctrl)
  );

  // Register bus runs in every state, including power-down
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg <= acpc_pkg::acpc_cfg_t'(`ACPC_CTRL_RESET);
    end else if (reg_write && reg_addr == `ACPC_ADDR_CTRL) begin
      cfg.sw_pd_en <= reg_wdata[`ACPC_CTRL_SW_PD_EN];
      cfg.sw_pd <= reg_wdata[`ACPC_CTRL_SW_PD];
      cfg.impulse <= reg_wdata[`ACPC_CTRL_IMPULSE];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ACPC_ST_BUSY] = busy;
    status_word[`ACPC_ST_PD] = powered_down;
    status_word[`ACPC_ST_LOWPWR] = low_power;
    status_word[`ACPC_ST_MODE_HI:`ACPC_ST_MODE_LO] = ref_mode;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `ACPC_ADDR_CTRL: reg_rdata <= {29'h0000_0000, cfg.impulse,
                                       cfg.sw_pd, cfg.sw_pd_en};
        `ACPC_ADDR_STATUS: reg_rdata <= status_word;
        `ACPC_ADDR_COUNT: reg_rdata <= {16'h0000, conv_count};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  AST_START_ON_EDGE: assert property (@(posedge core_clk) disable iff (!nrst)
    state == ACPC_ST_IDLE && start_edge |=> busy)
    else $error("start edge did not raise busy");
  // Checker helper: busy cycles so far, long runs cannot be unrolled
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_run <= '0;
    end else if (busy) begin
      busy_run <= busy_run + 1'b1;
    end else begin
      busy_run <= '0;
    end
  end

  AST_BUSY_LENGTH: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(busy) |-> busy_run == CW'(CONV_CYCLES))
    else $error("busy width wrong");
  AST_BUSY_MAX: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> busy_run <= CW'(CONV_CYCLES - 1))
    else $error("busy longer than one conversion");
  AST_NO_ABORT: assert property (@(posedge core_clk) disable iff (!nrst)
    busy && cycle_cnt != '0 |=> busy)
    else $error("conversion aborted");
  AST_PD_AFTER_CONV: assert property (@(posedge core_clk) disable iff (!nrst)
    busy && cycle_cnt == '0 && pd_request |=> powered_down)
    else $error("power-down not entered after conversion");
  AST_PD_PIN_IGNORED: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.sw_pd_en && !cfg.sw_pd && state == ACPC_ST_IDLE && !start_edge
    |=> !powered_down)
    else $error("pin power-down honoured under register control");
  AST_PD_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
    !cfg.sw_pd_en && powerdown_pin && state == ACPC_ST_IDLE && !start_edge
    |=> powered_down)
    else $error("pin power-down not honoured");
  AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(busy) |-> conv_done)
    else $error("no done pulse at busy fall");
  AST_IMPULSE_LOW: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.impulse && $fell(busy) && !powered_down |-> low_power)
    else $error("impulse low power not entered");
  AST_REF_INTERNAL: assert property (@(posedge core_clk) disable iff (!nrst)
    !ref_core_powerdown && !ref_buffer_powerdown && !powered_down
    |-> ref_ctrl.bandgap_en && ref_ctrl.temp_en)
    else $error("internal reference not enabled");
  AST_REF_BUFFERED: assert property (@(posedge core_clk) disable iff (!nrst)
    ref_core_powerdown && !ref_buffer_powerdown
    |-> !ref_ctrl.bandgap_en)
    else $error("bandgap on in buffered mode");
  AST_REF_DIRECT: assert property (@(posedge core_clk) disable iff (!nrst)
    ref_core_powerdown && ref_buffer_powerdown
    |-> !ref_ctrl.bandgap_en && !ref_ctrl.buffer_en)
    else $error("reference on in direct mode");
  AST_READ_IN_PD: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_read && reg_addr == `ACPC_ADDR_STATUS && powered_down
    |=> reg_rdata[`ACPC_ST_PD])
    else $error("bus dead in power-down");
  AST_START_IGNORES_CS: assert property (@(posedge core_clk)
    disable iff (!nrst)
    chip_select_n && read_enable_n && state == ACPC_ST_IDLE && start_edge
    |=> busy)
    else $error("start gated by select");

  // Conversion counter and done pulse
  AST_DONE_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_done |=> !conv_done)
    else $error("done pulse too long");
  AST_DONE_ONLY_AFTER: assert property (@(posedge core_clk)
    disable iff (!nrst) conv_done |-> !busy && $past(busy))
    else $error("done without conversion end");
  AST_NO_DONE_BUSY: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> !conv_done)
    else $error("done while busy");
  AST_COUNT_STEP: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_done |-> conv_count == $past(conv_count) + 16'h0001)
    else $error("conversion count not stepped");
  AST_COUNT_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !conv_done |-> $stable(conv_count))
    else $error("conversion count moved");
  AST_CNT_LOAD: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(busy) |-> cycle_cnt == CW'(CONV_CYCLES - 1))
    else $error("phase counter not loaded");

  // Register bus, alive in every state
  AST_RDATA_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    !$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  AST_READ_COUNT: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_read && reg_addr == `ACPC_ADDR_COUNT
    |=> reg_rdata == {16'h0000, $past(conv_count)})
    else $error("count read wrong");
  AST_READ_CTRL: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_read && reg_addr == `ACPC_ADDR_CTRL
    |=> reg_rdata[`ACPC_CTRL_IMPULSE] == $past(cfg.impulse) &&
        reg_rdata[`ACPC_CTRL_SW_PD] == $past(cfg.sw_pd) &&
        reg_rdata[`ACPC_CTRL_SW_PD_EN] == $past(cfg.sw_pd_en))
    else $error("control read wrong");
  AST_READ_BUSY: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_read && reg_addr == `ACPC_ADDR_STATUS
    |=> reg_rdata[`ACPC_ST_BUSY] == $past(busy))
    else $error("status busy read wrong");
  AST_WRITE_CTRL: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_write && reg_addr == `ACPC_ADDR_CTRL
    |=> cfg.impulse == $past(reg_wdata[`ACPC_CTRL_IMPULSE]))
    else $error("control write lost");

  // Power-down entry and exit
  AST_PD_LEAVE: assert property (@(posedge core_clk) disable iff (!nrst)
    powered_down && !pd_request |=> !powered_down)
    else $error("power-down not left");
  AST_PD_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    powered_down && pd_request |=> powered_down)
    else $error("power-down dropped early");
  AST_PD_NO_START: assert property (@(posedge core_clk) disable iff (!nrst)
    powered_down && start_edge |=> !busy)
    else $error("conversion started in power-down");
  AST_PD_MIN_REF: assert property (@(posedge core_clk) disable iff (!nrst)
    powered_down |-> ref_ctrl == '0)
    else $error("reference on in power-down");
  AST_PD_LOW_POWER: assert property (@(posedge core_clk) disable iff (!nrst)
    powered_down |-> low_power)
    else $error("power-down without low power");
  AST_BUSY_NOT_PD: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> !powered_down)
    else $error("power-down during conversion");
  AST_SW_PD: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.sw_pd_en && cfg.sw_pd && state == ACPC_ST_IDLE && !start_edge
    |=> powered_down)
    else $error("register power-down not honoured");
  AST_IDLE_STAYS: assert property (@(posedge core_clk) disable iff (!nrst)
    state == ACPC_ST_IDLE && !start_edge && !pd_request
    |=> state == ACPC_ST_IDLE)
    else $error("left idle without cause");

  // Impulse mode power saving
  AST_CONV_FULL_POWER: assert property (@(posedge core_clk)
    disable iff (!nrst) busy |-> !low_power)
    else $error("low power during conversion");
  AST_IMPULSE_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
    !cfg.impulse && !powered_down |-> !low_power)
    else $error("low power outside impulse mode");
  AST_IMPULSE_ACQ: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg.impulse && state == ACPC_ST_IDLE |-> low_power)
    else $error("acquisition not in low power");

  // Reference source decode
  AST_REF_BUF_ON: assert property (@(posedge core_clk) disable iff (!nrst)
    ref_core_powerdown && !ref_buffer_powerdown && !powered_down
    |-> ref_ctrl.buffer_en && !ref_ctrl.temp_en)
    else $error("buffer off in buffered mode");
  AST_MODE_INTERNAL: assert property (@(posedge core_clk) disable iff (!nrst)
    !ref_core_powerdown && !ref_buffer_powerdown
    |-> ref_mode == acpc_pkg::ACPC_REF_INTERNAL)
    else $error("internal mode not decoded");
  AST_MODE_BUFFERED: assert property (@(posedge core_clk) disable iff (!nrst)
    ref_core_powerdown && !ref_buffer_powerdown
    |-> ref_mode == acpc_pkg::ACPC_REF_EXT_BUFFERED)
    else $error("buffered mode not decoded");
  AST_MODE_DIRECT: assert property (@(posedge core_clk) disable iff (!nrst)
    ref_core_powerdown && ref_buffer_powerdown
    |-> ref_mode == acpc_pkg::ACPC_REF_EXT_DIRECT)
    else $error("direct mode not decoded");

  COV_CONVERSION: cover property (@(posedge core_clk) disable iff (!nrst)
    $fell(busy));
  COV_PD_DURING_CONV: cover property (@(posedge core_clk) disable iff (!nrst)
    busy && powerdown_pin ##[1:200] powered_down);
  COV_EDGE_WHILE_BUSY: cover property (@(posedge core_clk)
    disable iff (!nrst) busy && start_edge);
  COV_IMPULSE: cover property (@(posedge core_clk) disable iff (!nrst)
    cfg.impulse && low_power && !powered_down);
  COV_SW_PD: cover property (@(posedge core_clk) disable iff (!nrst)
    cfg.sw_pd_en && powered_down);

endmodule : acpc_conv_ctrl

//--- rtl/acpc_defs.svh
`ifndef ACPC_DEFS_SVH
`define ACPC_DEFS_SVH

// Register map (single flat address space, 4-bit index)
`define ACPC_ADDR_CTRL 4'h0
`define ACPC_ADDR_STATUS 4'h1
`define ACPC_ADDR_COUNT 4'h2

// Control register fields
`define ACPC_CTRL_SW_PD_EN 0
`define ACPC_CTRL_SW_PD 1
`define ACPC_CTRL_IMPULSE 2
`define ACPC_CTRL_RESET 3'h0

// Status register fields
`define ACPC_ST_BUSY 0
`define ACPC_ST_PD 1
`define ACPC_ST_LOWPWR 2
`define ACPC_ST_MODE_LO 3
`define ACPC_ST_MODE_HI 4

// Conversion phase length
`define ACPC_CONV_NS 1000
`define ACPC_CLK_NS 10
`define ACPC_CONV_CYC ((`ACPC_CONV_NS + `ACPC_CLK_NS - 1) / `ACPC_CLK_NS)

`endif

//--- rtl/acpc_pkg.sv
package acpc_pkg;

  typedef enum logic [1:0] {
    ACPC_REF_INTERNAL,
    ACPC_REF_EXT_BUFFERED,
    ACPC_REF_EXT_DIRECT
  } acpc_ref_mode_t;

  typedef struct packed {
    logic bandgap_en;
    logic buffer_en;
    logic temp_en;
  } acpc_ref_ctrl_t;

  typedef struct packed {
    logic sw_pd_en;
    logic sw_pd;
    logic impulse;
  } acpc_cfg_t;

endpackage : acpc_pkg

//--- rtl/acpc_ref_decode.sv
`timescale 1ns/1ps
module acpc_ref_decode (
  input wire logic ref_core_powerdown,
  input wire logic ref_buffer_powerdown,
  input wire logic powered_down,
  output acpc_pkg::acpc_ref_mode_t ref_mode,
  output acpc_pkg::acpc_ref_ctrl_t ref_ctrl
);

  always_comb begin
    ref_ctrl = '0;
    // Buffer low with core high is the only external-buffered case
    if (!ref_core_powerdown && !ref_buffer_powerdown) begin
      ref_mode = acpc_pkg::ACPC_REF_INTERNAL;
      ref_ctrl.bandgap_en = !powered_down;
      ref_ctrl.buffer_en = !powered_down;
      ref_ctrl.temp_en = !powered_down;
    end else if (ref_core_powerdown && !ref_buffer_powerdown) begin
      ref_mode = acpc_pkg::ACPC_REF_EXT_BUFFERED;
      ref_ctrl.buffer_en = !powered_down;
    end else begin
      // Core low with buffer high has no own mode; treated as direct
      ref_mode = acpc_pkg::ACPC_REF_EXT_DIRECT;
    end
  end

endmodule : acpc_ref_decode

//--- sim/acpc_host.sv
`timescale 1ns/1ps
module acpc_host (
  input wire logic core_clk,
  output logic convert_start_n,
  output logic powerdown_pin
);
  initial begin
    convert_start_n = 1'h1;
    powerdown_pin = 1'h0;
  end
  // One-cycle low pulse; the falling edge alone starts a conversion
  task automatic start();
    @(posedge core_clk);
    convert_start_n <= 1'h0;
    @(posedge core_clk);
    convert_start_n <= 1'h1;
  endtask : start
  task automatic pd(input logic v);
    @(posedge core_clk);
    powerdown_pin <= v;
  endtask : pd
endmodule : acpc_host

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int CONV = 4;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic convert_start_n, powerdown_pin;
  logic ref_core_powerdown = 1'h0;
  logic ref_buffer_powerdown = 1'h0;
  logic chip_select_n = 1'h1;
  logic read_enable_n = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic [31:0] reg_rdata, rd_v;
  logic busy, conv_done, powered_down, low_power;
  acpc_pkg::acpc_ref_mode_t ref_mode;
  acpc_pkg::acpc_ref_ctrl_t ref_ctrl;
  int n_mismatch = 0;
  int compares = 0;
  int n_conv = 0;
  int n;
  always #5 core_clk = ~core_clk;
  acpc_host u_host (.core_clk(core_clk), .convert_start_n(convert_start_n),
    .powerdown_pin(powerdown_pin));
  acpc_conv_ctrl #(.CONV_CYCLES(CONV)) u_dut (.core_clk(core_clk),
    .nrst(nrst), .convert_start_n(convert_start_n),
    .powerdown_pin(powerdown_pin), .ref_core_powerdown(ref_core_powerdown),
    .ref_buffer_powerdown(ref_buffer_powerdown),
    .chip_select_n(chip_select_n), .read_enable_n(read_enable_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy),
    .conv_done(conv_done), .powered_down(powered_down),
    .low_power(low_power), .ref_mode(ref_mode), .ref_ctrl(ref_ctrl));
  task automatic chk(input string s, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge core_clk);
    reg_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge core_clk);
    reg_read <= 1'h0;
    #1 rd_v = reg_rdata;
  endtask : rd
  // Counts the busy cycles still to come; power-down must wait for them
  task automatic wait_idle();
    n = 0;
    #1;
    while (busy === 1'h1 && n < 50) begin
      chk("pd_busy", powered_down, 0);
      n++;
      @(posedge core_clk);
      #1;
    end
    chk("done", conv_done, 1);
    n_conv++;
  endtask : wait_idle
  task automatic t_ref();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      ref_core_powerdown <= i[1];
      ref_buffer_powerdown <= i[0];
      #1;
      chk("mode", ref_mode, i == 0 ? 0 : i == 2 ? 1 : 2);
      chk("bg_buf", ref_ctrl[2:1], {i == 0, i[0] == 0});
      if (i == 0) chk("temp", ref_ctrl, 3'h7);
    end
    ref_core_powerdown <= 1'h0;
    ref_buffer_powerdown <= 1'h0;
  endtask : t_ref
  // Select and read enable held inactive throughout
  task automatic t_conv();
    u_host.start();
    wait_idle();
    chk("width", n, CONV);
    u_host.start();
    u_host.start();
    wait_idle();
    chk("restart", n, CONV - 2);
  endtask : t_conv
  task automatic t_pd();
    u_host.start();
    u_host.pd(1'h1);
    wait_idle();
    chk("pd_abort", n, CONV - 1);
    @(posedge core_clk);
    #1 chk("pd", powered_down, 1);
    chk("pd_ref", ref_ctrl, 0);
    chk("pd_lp", low_power, 1);
    u_host.start();
    #1 chk("pd_start", busy, 0);
    rd(4'h1);
    chk("pd_bus", rd_v, 32'h6);
    u_host.pd(1'h0);
    repeat (2) @(posedge core_clk);
    #1 chk("pd_off", powered_down, 0);
  endtask : t_pd
  task automatic t_sw();
    wr(4'h0, 32'h1);
    u_host.pd(1'h1);
    repeat (2) @(posedge core_clk);
    #1 chk("pin_ign", powered_down, 0);
    u_host.start();
    wait_idle();
    chk("sw_conv", n, CONV);
    wr(4'h0, 32'h3);
    repeat (2) @(posedge core_clk);
    #1 chk("sw_pd", powered_down, 1);
    u_host.pd(1'h0);
    wr(4'h0, 32'h0);
    repeat (2) @(posedge core_clk);
  endtask : t_sw
  task automatic t_imp();
    wr(4'h0, 32'h4);
    repeat (2) @(posedge core_clk);
    #1 chk("imp_idle", low_power, 1);
    u_host.start();
    #1 chk("imp_conv", low_power, 0);
    rd(4'h1);
    chk("imp_st_busy", rd_v, 32'h1);
    wait_idle();
    @(posedge core_clk);
    #1 chk("imp_acq", low_power, 1);
    rd(4'h1);
    chk("imp_st", rd_v, 32'h4);
    rd(4'h2);
    chk("count", rd_v, n_conv);
    rd(4'hF);
    chk("unmapped", rd_v, 0);
  endtask : t_imp
  task automatic end_sim();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    #1 chk("rst_busy", busy, 0);
    chk("rst_pd", powered_down, 0);
    t_ref();
    t_conv();
    t_pd();
    t_sw();
    t_imp();
    end_sim();
  end
  // Whole run is under a hundred cycles; 5000 cycles means a hang
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
endmodule : testbench
